// ### dv/swb_bridge_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module swb_bridge_top_tb;
  import swb_pkg::*;
  // shortened counts; the read sample (1875) must fall inside the write-zero low
  localparam logic [CNT_W-1:0] RL = 20'h0_04b0, RH = 20'h0_07d0, MP = 20'h0_05dc;
  localparam logic [CNT_W-1:0] SL = 20'h0_0960, W0 = 20'h0_07d0;
  typedef struct {logic [7:0] m; logic [7:0] v; int len;} swb_exp_t;
  logic       clk = 1'b0, rst = 1'b1, hlo, scl, sda_oe, sda_out, ptr;
  logic [2:0] sel = 3'h0;
  swb_cfg_t   cfg = '0;
  logic [7:0] pull = 8'h00, lo, oe, lout, st;
  int         n_mismatch = 0, num_checks = 0, blen = 0, smode = 0, seed = 32'h33d5_1675;
  swb_exp_t   q[$];
  swb_exp_t   e;
  always #4 clk = ~clk;
  assign lo = oe & ~lout;
  swb_host_model host (.clk(clk), .sda(~(hlo | sda_oe)), .scl(scl), .sda_lo(hlo));
  swb_bridge_top #(.RSTL_STD(RL), .RSTH_STD(RH), .MSP_STD(MP), .SLOT_STD(SL), .W0L_STD(W0)) dut (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(~(hlo | sda_oe)), .sda_out(sda_out), .sda_oe(sda_oe),
    .chan_sel(sel), .cfg(cfg), .line_in(~(lo | pull)), .line_out(lout), .line_oe(oe),
    .status_o(st), .read_ptr_status(ptr));
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    num_checks++;
    if (ex !== sn) begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
      n_mismatch++;
    end
  endtask : chk
  task automatic report_and_stop();
    chk("notes left", 0, q.size());
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // far-side slave on the selected lane: 1 presence, 2 short, 3 read-zero
  initial forever begin
    @(posedge clk iff lo[sel]);
    if (smode == 1 || smode == 2) @(posedge clk iff !lo[sel]);
    repeat (smode == 1 ? 1200 : 1) @(posedge clk);
    #1;
    pull[sel] = (smode > 0);
    repeat (smode == 1 ? 600 : smode == 2 ? 1900 : 2100) @(posedge clk);
    #1;
    pull = 8'h00;
    @(posedge clk iff !lo[sel]);
  end
  // watcher: when busy drops, the oldest note gives flags and busy length
  always @(negedge clk) begin
    if (st[0] === 1'b1) blen++;
    else if (blen > 0) begin
      e = q.pop_front();
      chk("status flags", e.v, st & e.m);
      chk("busy length", 1, blen >= e.len && blen <= e.len + 2);
      blen = 0;
    end
  end
  task automatic cmd(input logic [7:0] code, input logic [7:0] prm, input logic ok);
    logic       a;
    int         n;
    logic [7:0] d;
    host.start();
    host.wr_byte({DEV_ADDR, 1'b0}, a);
    host.wr_byte(code, a);
    chk("code ack", ok, a);
    for (n = 0; code == CMD_RESET && ok && n < 40 && lo[sel] !== 1'b1; n++) host.cyc(1);
    if (code == CMD_RESET && ok) chk("line start", 1, n <= START_MAX_CYC);
    if (code == CMD_SBIT) host.wr_byte(prm, a);
    if (code == CMD_SBIT) chk("bit byte ack", ok, a);
    host.stop();
    if (ok) chk("read pointer", 1, ptr);
    // poll the status byte over the host bus while the line is still busy
    if (ok) begin
      host.start();
      host.wr_byte({DEV_ADDR, 1'b1}, a);
      host.rd_byte(d);
      host.stop();
      chk("busy poll", 2'h3, {a, d[0]});
    end
  endtask : cmd
  // bounded wait for the line to go idle, then let the watcher pop its note
  task automatic wait_idle();
    int n;
    for (n = 0; n < 9000 && st[0] !== 1'b0; n++) host.cyc(1);
    if (n == 9000) chk("idle wait", 0, 1);
    if (n == 9000) report_and_stop();
    host.cyc(4);
  endtask : wait_idle
  initial begin
    logic v;
    logic z;
    host.cyc(16);
    rst = 1'b0;
    chk("pointer after reset", 0, ptr);
    host.cyc(4);
    // reset cycles with no slave, presence, short; a code while busy is refused
    for (int m = 0; m < 3; m++) begin
      cfg = '0;
      smode = m;
      sel = 3'($random(seed));
      q.push_back('{8'h06, {5'h00, m == 2, m > 0, 1'b0}, RL + RH});
      cmd(CMD_RESET, 8'h00, 1'b1);
      cmd(CMD_RESET, 8'h00, 1'b0);
      wait_idle();
      $display("reset test %0d done", m);
    end
    // slots: write zero, read one, write zero against a pull, read zero, then two at overdrive
    for (int k = 0; k < 6; k++) begin
      v = k[0];
      z = k[1];
      smode = z ? 3 : 0;
      sel = 3'($random(seed));
      cfg = swb_cfg_t'({k > 3, 2'($random(seed))});
      q.push_back('{8'h20, {2'h0, v & ~z, 5'h00}, k > 3 ? SLOT_OD_CYC : SL});
      cmd(CMD_SBIT, {v, 7'($random(seed))}, 1'b1);
      cmd(CMD_SBIT, 8'h80, 1'b0);
      wait_idle();
      $display("slot test %0d done", k);
    end
    report_and_stop();
  end
endmodule : swb_bridge_top_tb
`default_nettype wire

// ### dv/swb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side master; scl phases of 5 clocks keep the 80 ns period
module swb_host_model (
  input  wire logic clk,    // system clock
  input  wire logic sda,    // host data wire level
  output logic      scl,    // serial clock
  output logic      sda_lo  // pull data low
);
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  // inputs move just after the edge so sampling never races
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // one bit; data is read late in the high phase, after the slave's sync delay
  task automatic bit_io(input logic b, output logic r);
    sda_lo = ~b;
    cyc(5);
    scl = 1'b1;
    cyc(4);
    r = sda;
    cyc(1);
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    sda_lo = 1'b1;
    cyc(5);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_lo = 1'b1;
    cyc(5);
    scl = 1'b1;
    cyc(5);
    sda_lo = 1'b0;
    cyc(5);
  endtask : stop
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  // read one byte msb first, then refuse it so the slave ends the read
  task automatic rd_byte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask : rd_byte
endmodule : swb_host_model
`default_nettype wire

// ### hdl/swb_bridge_top.sv
// What this block does
// R1 - the reset command code, with no parameter, starts a reset-low and presence cycle on the chosen channel.
// R2 - during reset the line is sampled at the short and presence points and both flags are reported.
// R3 - busy lasts low plus high reset time, presence and short flags update at their offsets past the low.
// R4 - a reset code that arrives while busy is not acknowledged and causes no line activity.
// R5 - reset activity starts within 262.5 ns of the falling clock edge ending the code acknowledge.
// R6 - an accepted reset leaves the read pointer on the status byte for busy polling.
// R7 - the host should keep the strong pullup off during a reset, or presence may read wrong.
// R8 - both commands shape the line by the current speed, active pullup and strong pullup settings.
// R9 - the single-slot command writes a zero slot for value 0 and a write-one read slot for value 1.
// R10 - in every single slot the line is sampled at the read point into the slot result flag.
// R11 - a single-slot code that arrives while busy leaves code and bit byte unacknowledged and is dropped.
// R12 - slot activity starts within 262.5 ns of the falling clock edge after the top bit of the bit byte.
// R13 - busy reads 1 for the slot length during a single slot.
// R14 - an accepted single-slot command leaves the read pointer on the status byte.
// R15 - the slot value is bit 7 of the bit byte, the other seven bits are ignored.
// R16 - busy clears once the reset cycle or slot has run out, so the next command is accepted.
`timescale 1ns/1ps
`default_nettype none
module swb_bridge_top #(
  parameter logic [swb_pkg::CNT_W-1:0] RSTL_STD = swb_pkg::RSTL_STD_CYC, // reset low, standard
  parameter logic [swb_pkg::CNT_W-1:0] RSTH_STD = swb_pkg::RSTH_STD_CYC, // reset high, standard
  parameter logic [swb_pkg::CNT_W-1:0] MSP_STD  = swb_pkg::MSP_STD_CYC,  // presence sample
  parameter logic [swb_pkg::CNT_W-1:0] SLOT_STD = swb_pkg::SLOT_STD_CYC, // slot length
  parameter logic [swb_pkg::CNT_W-1:0] W0L_STD  = swb_pkg::W0L_STD_CYC,  // write-zero low
  parameter logic [swb_pkg::CNT_W-1:0] RSTL_OD  = swb_pkg::RSTL_OD_CYC,  // reset low, overdrive
  parameter logic [swb_pkg::CNT_W-1:0] RSTH_OD  = swb_pkg::RSTH_OD_CYC   // reset high, overdrive
) (
  input  wire logic              clk,             // system clock, 125 MHz
  input  wire logic              rst,             // async reset, active high
  input  wire logic              scl,             // host serial clock pin
  input  wire logic              sda_in,          // host data pin level
  output logic                   sda_out,         // host data drive value
  output logic                   sda_oe,          // host data pulled low when high
  input  wire logic [2:0]        chan_sel,        // selected line channel
  input  wire swb_pkg::swb_cfg_t cfg,             // speed, active and strong pullup
  input  wire logic [7:0]        line_in,         // line pin levels
  output logic [7:0]             line_out,        // line drive values
  output logic [7:0]             line_oe,         // line drive enables
  output logic [7:0]             status_o,        // status byte
  output logic                   read_ptr_status  // read pointer rests on status
);
  import swb_pkg::*;

  localparam int START_WIN = int'(START_MAX_CYC);

  swb_top_t s;
  swb_top_t n;

  logic     scl_rise;
  logic     scl_fall;
  logic     bus_start;
  logic     bus_stop;
  logic     sel_lvl;
  logic     line_drive;
  logic     eng_busy;
  logic     eng_lo;
  logic     eng_hi;
  swb_evt_t eng_evt;

  // one-hot lane of the chosen channel
  function automatic logic [7:0] chan_mask(input logic [2:0] c);
    return 8'h01 << c;
  endfunction : chan_mask

  // host pin events, seen only after the two synchroniser stages
  assign scl_rise  = s.scl_sy[1] && !s.scl_d;
  assign scl_fall  = !s.scl_sy[1] && s.scl_d;
  assign bus_start = s.scl_sy[1] && s.scl_d && s.sda_d && !s.sda_sy[1];
  assign bus_stop  = s.scl_sy[1] && s.scl_d && !s.sda_d && s.sda_sy[1];
  assign sel_lvl   = s.ln_s2[chan_sel];

  // strong pullup counts as a drive so the wire stays hard high after a slot
  assign line_drive = eng_lo || eng_hi || s.spu_on;

  swb_slot_engine #(
    .RSTL_STD (RSTL_STD),
    .RSTH_STD (RSTH_STD),
    .MSP_STD  (MSP_STD),
    .SLOT_STD (SLOT_STD),
    .W0L_STD  (W0L_STD),
    .RSTL_OD  (RSTL_OD),
    .RSTH_OD  (RSTH_OD)
  ) u_engine (
    .clk        (clk),
    .rst        (rst),
    .go_reset   (s.go_rst),
    .go_slot    (s.go_slot),
    .slot_bit   (s.slot_bit),
    .cfg        (cfg),
    .line_lvl   (sel_lvl),
    .busy       (eng_busy),
    .drive_low  (eng_lo),
    .drive_high (eng_hi),
    .evt        (eng_evt)
  );

  // next state of the whole top
  always_comb begin
    n = s;
    // synchronisers: stage one feeds stage two only
    n.scl_sy     = {s.scl_sy[0], scl};
    n.sda_sy     = {s.sda_sy[0], sda_in};
    n.scl_d      = s.scl_sy[1];
    n.sda_d      = s.sda_sy[1];
    n.ln_s1      = line_in;
    n.ln_s2      = s.ln_s1;
    n.go_rst     = 1'b0;
    n.go_slot    = 1'b0;
    n.eng_busy_d = eng_busy;

    // status byte follows the engine
    n.status[ST_BUSY] = eng_busy; // R13
    n.status[ST_LL]   = sel_lvl;
    if (eng_evt.sd_stb) begin
      n.status[ST_SD] = eng_evt.sd_val;   // R3
    end
    if (eng_evt.ppd_stb) begin
      n.status[ST_PPD] = eng_evt.ppd_val; // R3
    end
    if (eng_evt.sbr_stb) begin
      n.status[ST_SBR] = eng_evt.sbr_val; // R10
    end

    // strong pullup switches on as a cycle ends and off as the next one starts
    if (s.go_rst || s.go_slot) begin
      n.spu_on = 1'b0;
    end else if (s.eng_busy_d && !eng_busy && cfg.strong_pullup_enable) begin
      n.spu_on = 1'b1; // R8
    end

    // line pins: only the chosen channel ever moves
    n.line_oe  = line_drive ? chan_mask(chan_sel) : 8'h00;
    n.line_out = eng_lo ? 8'h00 : chan_mask(chan_sel);

    // host byte engine; data moves only on clock falls, so own drive never looks like start
    if (bus_start) begin
      n.st     = I2C_ADDR;
      n.bitn   = 4'h0;
      n.sda_oe = 1'b0;
    end else if (bus_stop) begin
      n.st      = I2C_IDLE;
      n.sda_oe  = 1'b0;
      n.arm_rst = 1'b0;
    end else if (s.st != I2C_IDLE) begin
      if (scl_rise) begin
        n.sh   = {s.sh[6:0], s.sda_sy[1]};
        n.bitn = s.bitn + 4'h1;
      end else if (scl_fall) begin
        if (s.bitn == 4'h8) begin
          // eighth bit done: decide the acknowledge
          n.sda_oe = 1'b0;
          case (s.st)
            I2C_ADDR: begin
              if (s.sh[7:1] == DEV_ADDR) begin
                n.sda_oe = 1'b1;
                n.rw     = s.sh[0];
              end else begin
                n.st = I2C_SKIP;
              end
            end
            I2C_CMD: begin
              if (eng_busy) begin
                n.st = I2C_SKIP;             // R4 R11
              end else if (s.sh == CMD_RESET) begin
                n.sda_oe        = 1'b1;
                n.arm_rst       = 1'b1;
                n.rd_ptr_status = 1'b1;      // R6
              end else if (s.sh == CMD_SBIT) begin
                n.sda_oe        = 1'b1;
                n.rd_ptr_status = 1'b1;      // R14
              end else begin
                n.st = I2C_SKIP;             // codes this block does not run
              end
            end
            I2C_PARAM: begin
              n.sda_oe = 1'b1;
            end
            default: begin
              n.sda_oe = 1'b0;
            end
          endcase
        end else if (s.bitn == 4'h9) begin
          // acknowledge clock done
          n.bitn   = 4'h0;
          n.sda_oe = 1'b0;
          case (s.st)
            I2C_ADDR: begin
              n.st = s.rw ? I2C_READ : I2C_CMD;
              if (s.rw) begin
                n.tx     = s.status;
                n.sda_oe = !s.status[7];
              end
            end
            I2C_CMD: begin
              if (s.arm_rst) begin
                n.go_rst  = 1'b1;            // R5
                n.arm_rst = 1'b0;
                n.st      = I2C_SKIP;
              end else begin
                n.st = I2C_PARAM;
              end
            end
            I2C_READ: begin
              // host acknowledge repeats the status byte, a refusal ends the read
              if (!s.sh[0]) begin
                n.tx     = s.status;
                n.sda_oe = !s.status[7];
              end else begin
                n.st = I2C_SKIP;
              end
            end
            default: begin
              n.st = I2C_SKIP;
            end
          endcase
        end else begin
          if (s.st == I2C_READ) begin
            n.sda_oe = !s.tx[3'(4'h7 - s.bitn)];
          end
          // slot starts as soon as the top bit is in, before the rest of the byte
          if ((s.st == I2C_PARAM) && (s.bitn == 4'h1)) begin
            n.go_slot  = 1'b1;               // R12
            n.slot_bit = s.sh[0];            // R15
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= TOP_RST;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register; data line is open drain
  assign sda_out         = 1'b0;
  assign sda_oe          = s.sda_oe;
  assign line_out        = s.line_out;
  assign line_oe         = s.line_oe;
  assign status_o        = s.status;
  assign read_ptr_status = s.rd_ptr_status;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rst_ack_end;
    scl_fall && (s.bitn == 4'h9) && (s.st == I2C_CMD) && s.arm_rst;
  endsequence

  sequence slot_top_bit;
    scl_fall && (s.bitn == 4'h1) && (s.st == I2C_PARAM);
  endsequence

  sequence code_while_busy(logic [7:0] code);
    scl_fall && (s.bitn == 4'h8) && (s.st == I2C_CMD) && eng_busy && (s.sh == code);
  endsequence

  chk_reset_nack: assert property (code_while_busy(CMD_RESET) |=> !s.sda_oe && (s.st == I2C_SKIP)) // R4
    else $error("reset code acknowledged while busy");
  chk_slot_nack: assert property (code_while_busy(CMD_SBIT) |=> !s.sda_oe [*2]) // R11
    else $error("slot code acknowledged while busy");
  chk_reset_start: assert property (rst_ack_end |-> ##[1:START_WIN]
                                    ((line_oe != 8'h00) && ((line_out & line_oe) == 8'h00))) // R5
    else $error("reset low not started in time");
  chk_slot_start: assert property (slot_top_bit |-> ##[1:START_WIN]
                                   ((line_oe != 8'h00) && ((line_out & line_oe) == 8'h00))) // R12
    else $error("slot low not started in time");
  chk_slot_bit7: assert property (slot_top_bit |=> s.go_slot && (s.slot_bit == $past(s.sh[0]))) // R15
    else $error("slot value not taken from the top bit");
  chk_ptr_reset: assert property (s.go_rst |-> s.rd_ptr_status) // R6
    else $error("read pointer not on status after reset command");
  chk_ptr_slot: assert property (s.go_slot |-> s.rd_ptr_status) // R14
    else $error("read pointer not on status after slot command");
  chk_busy_flag: assert property (s.go_slot |-> ##2 status_o[ST_BUSY] [*4]) // R13
    else $error("busy flag not raised for the slot");

endmodule : swb_bridge_top
`default_nettype wire

// ### hdl/swb_pkg.sv
package swb_pkg;

  // clock rate and counter width
  localparam int unsigned CLK_MHZ = 125;
  localparam int          CNT_W   = 20;

  // least times round up to whole clock cycles
  function automatic logic [CNT_W-1:0] ceil_cyc(input int unsigned ns);
    return CNT_W'((ns * CLK_MHZ + 999) / 1000);
  endfunction : ceil_cyc

  // host command codes and our bus address
  localparam logic [7:0] CMD_RESET = 8'hb4;
  localparam logic [7:0] CMD_SBIT  = 8'h87;
  localparam logic [6:0] DEV_ADDR  = 7'h18;
  localparam int         SBIT_POS  = 7;    // slot value is the first (top) bit of the bit byte

  // status byte layout
  localparam int         ST_BUSY    = 0;
  localparam int         ST_PPD     = 1;
  localparam int         ST_SD      = 2;
  localparam int         ST_LL      = 3;
  localparam int         ST_SBR     = 5;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // line timing, standard speed, in ns
  localparam int unsigned RSTL_STD_NS = 560000;
  localparam int unsigned RSTH_STD_NS = 560000;
  localparam int unsigned MSP_STD_NS  = 68000;
  localparam int unsigned SI_STD_NS   = 8000;
  localparam int unsigned SLOT_STD_NS = 70000;
  localparam int unsigned MSR_STD_NS  = 15000;
  localparam int unsigned W0L_STD_NS  = 60000;
  localparam int unsigned W1L_STD_NS  = 8000;
  // line timing, overdrive speed, in ns
  localparam int unsigned RSTL_OD_NS  = 70000;
  localparam int unsigned RSTH_OD_NS  = 70000;
  localparam int unsigned MSP_OD_NS   = 9000;
  localparam int unsigned SI_OD_NS    = 1000;
  localparam int unsigned SLOT_OD_NS  = 10000;
  localparam int unsigned MSR_OD_NS   = 2000;
  localparam int unsigned W0L_OD_NS   = 8000;
  localparam int unsigned W1L_OD_NS   = 1000;
  localparam int unsigned APU_NS      = 250;
  // latest start of line activity after the host edge, in ps
  localparam int unsigned START_MAX_PS = 262500;

  // cycle counts
  localparam logic [CNT_W-1:0] RSTL_STD_CYC = ceil_cyc(RSTL_STD_NS);
  localparam logic [CNT_W-1:0] RSTH_STD_CYC = ceil_cyc(RSTH_STD_NS);
  localparam logic [CNT_W-1:0] MSP_STD_CYC  = ceil_cyc(MSP_STD_NS);
  localparam logic [CNT_W-1:0] SI_STD_CYC   = ceil_cyc(SI_STD_NS);
  localparam logic [CNT_W-1:0] SLOT_STD_CYC = ceil_cyc(SLOT_STD_NS);
  localparam logic [CNT_W-1:0] MSR_STD_CYC  = ceil_cyc(MSR_STD_NS);
  localparam logic [CNT_W-1:0] W0L_STD_CYC  = ceil_cyc(W0L_STD_NS);
  localparam logic [CNT_W-1:0] W1L_STD_CYC  = ceil_cyc(W1L_STD_NS);
  localparam logic [CNT_W-1:0] RSTL_OD_CYC  = ceil_cyc(RSTL_OD_NS);
  localparam logic [CNT_W-1:0] RSTH_OD_CYC  = ceil_cyc(RSTH_OD_NS);
  localparam logic [CNT_W-1:0] MSP_OD_CYC   = ceil_cyc(MSP_OD_NS);
  localparam logic [CNT_W-1:0] SI_OD_CYC    = ceil_cyc(SI_OD_NS);
  localparam logic [CNT_W-1:0] SLOT_OD_CYC  = ceil_cyc(SLOT_OD_NS);
  localparam logic [CNT_W-1:0] MSR_OD_CYC   = ceil_cyc(MSR_OD_NS);
  localparam logic [CNT_W-1:0] W0L_OD_CYC   = ceil_cyc(W0L_OD_NS);
  localparam logic [CNT_W-1:0] W1L_OD_CYC   = ceil_cyc(W1L_OD_NS);
  localparam logic [CNT_W-1:0] APU_CYC      = ceil_cyc(APU_NS);
  // longest time rounds down
  localparam int unsigned      START_MAX_CYC = START_MAX_PS * CLK_MHZ / 1000000;

  // state encodings
  typedef enum logic [1:0] {ENG_IDLE = 2'h1, ENG_RUN = 2'h2} swb_eng_st_t;
  typedef enum logic [5:0] {
    I2C_IDLE  = 6'h01,
    I2C_ADDR  = 6'h02,
    I2C_CMD   = 6'h04,
    I2C_PARAM = 6'h08,
    I2C_READ  = 6'h10,
    I2C_SKIP  = 6'h20
  } swb_i2c_st_t;

  typedef struct packed {logic od; logic active_pullup_enable; logic strong_pullup_enable;} swb_cfg_t;
  typedef struct packed {
    logic sd_stb; logic sd_val; logic ppd_stb; logic ppd_val; logic sbr_stb; logic sbr_val;
  } swb_evt_t;
  typedef struct packed {
    logic [CNT_W-1:0] total; logic [CNT_W-1:0] low; logic [CNT_W-1:0] pt_a; logic [CNT_W-1:0] pt_b;
  } swb_tim_t;

  typedef struct packed {
    swb_eng_st_t st; logic is_rst; logic od; logic active_pullup_enable; logic bitv;
    logic [CNT_W-1:0] cnt; logic drv_lo; logic drv_hi; swb_evt_t evt;
  } swb_eng_t;

  typedef struct packed {
    swb_i2c_st_t st; logic [1:0] scl_sy; logic [1:0] sda_sy; logic scl_d; logic sda_d;
    logic [7:0] ln_s1; logic [7:0] ln_s2; logic [3:0] bitn; logic [7:0] sh; logic [7:0] tx;
    logic rw; logic arm_rst; logic go_rst; logic go_slot; logic slot_bit; logic eng_busy_d;
    logic spu_on; logic [7:0] status; logic rd_ptr_status; logic sda_oe;
    logic [7:0] line_out; logic [7:0] line_oe;
  } swb_top_t;

  localparam swb_eng_t ENG_RST = '{st: ENG_IDLE, default: '0};
  localparam swb_top_t TOP_RST = '{st: I2C_IDLE, status: STATUS_RST, default: '0};

endpackage : swb_pkg

// ### hdl/swb_slot_engine.sv
`timescale 1ns/1ps
`default_nettype none
module swb_slot_engine #(
  parameter logic [swb_pkg::CNT_W-1:0] RSTL_STD = swb_pkg::RSTL_STD_CYC, // reset low, standard
  parameter logic [swb_pkg::CNT_W-1:0] RSTH_STD = swb_pkg::RSTH_STD_CYC, // reset high, standard
  parameter logic [swb_pkg::CNT_W-1:0] MSP_STD  = swb_pkg::MSP_STD_CYC,  // presence sample
  parameter logic [swb_pkg::CNT_W-1:0] SLOT_STD = swb_pkg::SLOT_STD_CYC, // slot length
  parameter logic [swb_pkg::CNT_W-1:0] W0L_STD  = swb_pkg::W0L_STD_CYC,  // write-zero low
  parameter logic [swb_pkg::CNT_W-1:0] RSTL_OD  = swb_pkg::RSTL_OD_CYC,  // reset low, overdrive
  parameter logic [swb_pkg::CNT_W-1:0] RSTH_OD  = swb_pkg::RSTH_OD_CYC   // reset high, overdrive
) (
  input  wire logic              clk,        // system clock
  input  wire logic              rst,        // async reset, active high
  input  wire logic              go_reset,   // start reset/presence cycle
  input  wire logic              go_slot,    // start single time slot
  input  wire logic              slot_bit,   // value written in the slot
  input  wire swb_pkg::swb_cfg_t cfg,        // speed and pullup settings
  input  wire logic              line_lvl,   // synchronised line level
  output logic                   busy,       // cycle in progress
  output logic                   drive_low,  // pull the line low
  output logic                   drive_high, // active pullup pulse
  output swb_pkg::swb_evt_t      evt         // sample strobes and values
);
  import swb_pkg::*;

  swb_eng_t s;
  swb_eng_t n;
  swb_tim_t t;
  logic [CNT_W-1:0] nxt;

  // per-command waveform figures, chosen by kind and speed
  function automatic swb_tim_t timing(input logic is_rst, input logic od, input logic bitv);
    swb_tim_t r;
    if (is_rst) begin
      r.low   = od ? RSTL_OD : RSTL_STD;
      r.total = r.low + (od ? RSTH_OD : RSTH_STD);
      r.pt_a  = r.low + (od ? SI_OD_CYC : SI_STD_CYC);
      r.pt_b  = r.low + (od ? MSP_OD_CYC : MSP_STD);
    end else begin
      r.low   = od ? (bitv ? W1L_OD_CYC : W0L_OD_CYC) : (bitv ? W1L_STD_CYC : W0L_STD);
      r.total = od ? SLOT_OD_CYC : SLOT_STD;
      r.pt_a  = od ? MSR_OD_CYC : MSR_STD_CYC;
      r.pt_b  = r.total; // never reached in a slot
    end
    return r;
  endfunction : timing

  assign t   = timing(s.is_rst, s.od, s.bitv);
  assign nxt = s.cnt + CNT_W'(1);

  // next state: one counter walks the whole cycle, phases are compares against it
  always_comb begin
    n     = s;
    n.evt = '0;
    case (s.st)
      ENG_IDLE: begin
        if (go_reset || go_slot) begin
          n.st     = ENG_RUN;
          n.is_rst = go_reset;  // R1
          n.od     = cfg.od;    // R8
          n.active_pullup_enable    = cfg.active_pullup_enable;   // R8
          n.bitv   = slot_bit;  // R9
          n.cnt    = '0;
          n.drv_lo = 1'b1;
          n.drv_hi = 1'b0;
        end
      end
      ENG_RUN: begin
        n.cnt    = nxt;
        n.drv_lo = (nxt < t.low);                                   // R9
        n.drv_hi = s.active_pullup_enable && (nxt >= t.low) && (nxt < t.low + APU_CYC); // R8
        // a low line at the first reset sample means a short, at the second a presence
        if (s.cnt == t.pt_a) begin
          if (s.is_rst) begin
            n.evt.sd_stb = 1'b1;       // R2
            n.evt.sd_val = !line_lvl;
          end else begin
            n.evt.sbr_stb = 1'b1;      // R10
            n.evt.sbr_val = line_lvl;
          end
        end
        if (s.is_rst && (s.cnt == t.pt_b)) begin
          n.evt.ppd_stb = 1'b1;        // R2
          n.evt.ppd_val = !line_lvl;
        end
        if (s.cnt == t.total - CNT_W'(1)) begin
          n.st     = ENG_IDLE;         // R16
          n.cnt    = '0;
          n.drv_lo = 1'b0;
          n.drv_hi = 1'b0;
        end
      end
      default: n = ENG_RST;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= ENG_RST;
    end else begin
      s <= n;
    end
  end

  assign busy       = (s.st == ENG_RUN); // R13
  assign drive_low  = s.drv_lo;
  assign drive_high = s.drv_hi;
  assign evt        = s.evt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence zero_slot_start;
    (s.st == ENG_IDLE) && go_slot && !go_reset && !slot_bit;
  endsequence

  chk_reset_starts: assert property ((s.st == ENG_IDLE) && go_reset |=> busy && drive_low && s.is_rst) // R1
    else $error("reset cycle did not start low");
  chk_zero_low: assert property (zero_slot_start |=> drive_low [*8]) // R9
    else $error("write-zero slot released early");
  // sample points are held against the raw timing figures, not the shared decode
  chk_sd_point: assert property (evt.sd_stb |-> $past(s.is_rst) && ($past(s.cnt) == // R2
                                 (s.od ? RSTL_OD + SI_OD_CYC : RSTL_STD + SI_STD_CYC)))
    else $error("short sample at wrong time");
  chk_ppd_point: assert property (evt.ppd_stb |-> $past(s.cnt) == // R3
                                  (s.od ? RSTL_OD + MSP_OD_CYC : RSTL_STD + MSP_STD))
    else $error("presence sample at wrong time");
  chk_sbr_point: assert property (evt.sbr_stb |-> !$past(s.is_rst) && ($past(s.cnt) == // R10
                                  (s.od ? MSR_OD_CYC : MSR_STD_CYC)))
    else $error("slot sample at wrong time");
  chk_busy_total: assert property ($fell(busy) |-> $past(s.cnt) == (s.is_rst ? // R16
                                   (s.od ? RSTL_OD + RSTH_OD : RSTL_STD + RSTH_STD) :
                                   (s.od ? SLOT_OD_CYC : SLOT_STD)) - CNT_W'(1))
    else $error("busy length differs from cycle length");
  chk_cfg_latch: assert property ((s.st == ENG_IDLE) && (go_reset || go_slot)
                                  |=> (s.od == $past(cfg.od)) && (s.active_pullup_enable == $past(cfg.active_pullup_enable))) // R8
    else $error("speed or pullup setting not taken");

endmodule : swb_slot_engine
`default_nettype wire
